// ==== dma_reload_defines.vh ====
// Constants of the reload channel: register map, fields, encodings
`ifndef DMA_RELOAD_DEFINES_VH
`define DMA_RELOAD_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_SRC      8'h00
`define OFS_DST      8'h04
`define OFS_CNT      8'h08
`define OFS_CTRL     8'h0c
`define OFS_OPER     8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_CLR  8'h18
`define OFS_IRQ_EN   8'h1c
`define OFS_STATE    8'h20

// ----------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------
`define CTRL_DE      0
`define CTRL_TE      1
`define CTRL_IE      2
`define CTRL_RO      3
`define CTRL_BURST   4
`define CTRL_SM_LO   5
`define CTRL_SM_HI   6
`define CTRL_DM_LO   7
`define CTRL_DM_HI   8
`define CTRL_TS_LO   9
`define CTRL_TS_HI   10
`define CTRL_W       11
`define CTRL_RST     11'h000

// Operation register fields
`define OPER_DME     0
`define OPER_NMIF    1
`define OPER_AE      2
`define OPER_W       3

// Interrupt event bits
`define EV_END       0
`define EV_RELOAD    1
`define EV_ADDR_ERR  2
`define EV_W         3

// ----------------------------------------------------------------------
// Encodings and counts
// ----------------------------------------------------------------------
`define AMODE_FIXED  2'b00
`define AMODE_INC    2'b01
`define AMODE_DEC    2'b10
`define SIZE_BYTE    2'b00
`define SIZE_WORD    2'b01
`define SIZE_LONG    2'b10
`define STEP_BYTE    32'h0000_0001
`define STEP_WORD    32'h0000_0002
`define STEP_LONG    32'h0000_0004
`define RELOAD_UNITS 2'b11
`define RELOAD_CHAN  2
`define CNT_ONE      32'h0000_0001
`define ZERO32       32'h0000_0000

`endif

// ==== addr_step.v ====
// Address advance for one unit: fixed, increment or decrement by size
`timescale 1ns/1ps
module addr_step (
  input  wire [31:0] addr_i,
  input  wire [1:0]  mode_i,
  input  wire [1:0]  size_i,
  output reg  [31:0] next_o
);
`include "dma_reload_defines.vh"
  reg [31:0] step;

  // Step size then direction
  always @* begin
    case (size_i)
      `SIZE_WORD: step = `STEP_WORD;
      `SIZE_LONG: step = `STEP_LONG;
      default:    step = `STEP_BYTE;
    endcase
    case (mode_i)
      `AMODE_INC: next_o = addr_i + step;
      `AMODE_DEC: next_o = addr_i - step;
      default:    next_o = addr_i;
    endcase
  end
endmodule // addr_step

// ==== unit_counter.v ====
// Two-bit count of completed units, wrap flag on the fourth
`timescale 1ns/1ps
module unit_counter (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       clear_i,
  input  wire       tick_i,
  output wire       wrap_o,
  output reg  [1:0] count_o
);
`include "dma_reload_defines.vh"
  // Wrap seen by the tick that completes the fourth unit
  assign wrap_o = tick_i && (count_o == `RELOAD_UNITS);

  // Clear outranks a tick so a halted channel restarts at zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 2'b00;
    end else if (clear_i) begin
      count_o <= 2'b00;
    end else if (tick_i) begin
      count_o <= count_o + 2'b01;
    end
  end
endmodule // unit_counter

// ==== dma_reload_channel.v ====
// DMA channel with four-unit source reload, APB registers and interrupt
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - With reload on, source address returns to start after every fourth unit.
// - With reload on, channel halts after fourth unit and drops bus request.
// - Reload off in burst: keep bus after fourth unit, source keeps advancing.
// - Burst mode keeps the bus between units without new arbitration.
// - Reload point with reload on clears peripheral request flag unless the count ends there; off does not.
// - No end interrupt at reload point; only at count zero with enable set.
// - Destination address follows its own mode every unit, reload or not.
// - Byte units with increment advance the address by one.
// - Only channel index 2 reloads, by its reload bit, any unit size.
// - Transfer count drops by one after every unit.
// - Unit counter cleared by enables, end flag, NMI, address error, standby.
// - Count reaching zero sets end flag and requests end interrupt if enabled.
module dma_reload_channel #(
  parameter CHANNEL_INDEX = 2
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        periph_req_i,
  output wire        periph_flag_clr_o,
  output wire        bus_req_o,
  input  wire        bus_grant_i,
  output wire        unit_valid_o,
  input  wire        unit_done_i,
  output wire [31:0] src_addr_o,
  output wire [31:0] dst_addr_o,
  output wire [1:0]  unit_size_o,
  input  wire        nmi_i,
  input  wire        addr_error_i,
  input  wire        standby_i,
  output wire        transfer_end_interrupt_o,
  output wire        irq_o
);
`include "dma_reload_defines.vh"

  localparam ST_IDLE = 2'b00;
  localparam ST_REQ  = 2'b01;
  localparam ST_XFER = 2'b10;

  reg  [1:0]          rst_sync_reg;
  wire                rst_n;
  reg  [31:0]         source_address_reg;
  reg  [31:0]         source_shadow_reg;
  reg  [31:0]         dest_address_reg;
  reg  [31:0]         transfer_count_reg;
  reg  [`CTRL_W-1:0]  channel_control_reg;
  reg  [`OPER_W-1:0]  dma_operation_reg;
  reg  [`EV_W-1:0]    irq_stat_reg;
  reg  [`EV_W-1:0]    irq_en_reg;
  reg  [31:0]         prdata_reg;
  reg                 flag_clr_reg;
  reg  [1:0]          state_reg;
  reg  [1:0]          state_next;
  wire [31:0]         src_step;
  wire [31:0]         dst_step;
  wire [1:0]          units_done;
  wire                wrap;
  wire                wr_en;
  wire                rd_setup;
  wire                mapped;
  wire                channel_enable_bit;
  wire                transfer_end_flag;
  wire                end_interrupt_enable;
  wire                source_reload_enable;
  wire                burst_mode;
  wire                master_enable_bit;
  wire                nmi_flag;
  wire                address_error_flag;
  wire                reload_on;
  wire                active;
  wire                unit_end;
  wire                last_unit;
  wire                reload_halt;
  wire                cnt_clear;
  wire [`EV_W-1:0]    ev_set;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Asynchronous assert, two-stage synchronous release
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  assign channel_enable_bit   = channel_control_reg[`CTRL_DE];
  assign transfer_end_flag    = channel_control_reg[`CTRL_TE];
  assign end_interrupt_enable = channel_control_reg[`CTRL_IE];
  assign source_reload_enable = channel_control_reg[`CTRL_RO];
  assign burst_mode           = channel_control_reg[`CTRL_BURST];
  assign master_enable_bit    = dma_operation_reg[`OPER_DME];
  assign nmi_flag             = dma_operation_reg[`OPER_NMIF];
  assign address_error_flag   = dma_operation_reg[`OPER_AE];
  assign unit_size_o = channel_control_reg[`CTRL_TS_HI:`CTRL_TS_LO];

  assign reload_on = source_reload_enable &&
                     (CHANNEL_INDEX == `RELOAD_CHAN);

  // Channel may start or continue a unit
  assign active = master_enable_bit && channel_enable_bit &&
                  !transfer_end_flag && !nmi_flag &&
                  !address_error_flag && (transfer_count_reg != `ZERO32);

  // ----------------------------------------------------------------------
  // Unit accounting
  // ----------------------------------------------------------------------
  assign unit_end    = (state_reg == ST_XFER) && unit_done_i;
  assign last_unit   = transfer_count_reg == `CNT_ONE;
  // halt on the fourth unit, unless the count just ended
  assign reload_halt = wrap && reload_on && !last_unit;

  // counter clear sources; registers are left alone
  assign cnt_clear = !master_enable_bit || !channel_enable_bit ||
                     transfer_end_flag || nmi_flag ||
                     address_error_flag || standby_i;

  unit_counter u_unit_counter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .clear_i (cnt_clear),
    .tick_i  (unit_end),
    .wrap_o  (wrap),
    .count_o (units_done)
  );

  // byte increment gives a step of one
  addr_step u_src_step (
    .addr_i (source_address_reg),
    .mode_i (channel_control_reg[`CTRL_SM_HI:`CTRL_SM_LO]),
    .size_i (unit_size_o),
    .next_o (src_step)
  );

  addr_step u_dst_step (
    .addr_i (dest_address_reg),
    .mode_i (channel_control_reg[`CTRL_DM_HI:`CTRL_DM_LO]),
    .size_i (unit_size_o),
    .next_o (dst_step)
  );

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  // Next state; aborts take effect only between units
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // stale flag ignored while its clear is still in flight
        if (active && periph_req_i && !flag_clr_reg) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!active) begin
          state_next = ST_IDLE;
        end else if (bus_grant_i) begin
          state_next = ST_XFER;
        end
      end
      ST_XFER: begin
        if (unit_done_i) begin
          // burst keeps the bus; past the fourth unit only without reload
          if (last_unit || reload_halt || !burst_mode ||
              !active || !periph_req_i) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request dropped once the sequencer returns idle
  assign bus_req_o    = (state_reg == ST_REQ) || (state_reg == ST_XFER);
  assign unit_valid_o = state_reg == ST_XFER;
  assign src_addr_o   = source_address_reg;
  assign dst_addr_o   = dest_address_reg;

  // one-cycle flag clear only at a reload halt
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flag_clr_reg <= 1'b0;
    end else begin
      flag_clr_reg <= unit_end && reload_halt;
    end
  end
  assign periph_flag_clr_o = flag_clr_reg;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero-wait access; read data captured in the setup cycle
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign mapped   = (paddr_i == `OFS_SRC) || (paddr_i == `OFS_DST) ||
                    (paddr_i == `OFS_CNT) || (paddr_i == `OFS_CTRL) ||
                    (paddr_i == `OFS_OPER) ||
                    (paddr_i == `OFS_IRQ_STAT) ||
                    (paddr_i == `OFS_IRQ_CLR) ||
                    (paddr_i == `OFS_IRQ_EN) || (paddr_i == `OFS_STATE);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o  = prdata_reg;

  // Read mux; clear register reads as zero
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= `ZERO32;
    end else if (rd_setup) begin
      case (paddr_i)
        `OFS_SRC:      prdata_reg <= source_address_reg;
        `OFS_DST:      prdata_reg <= dest_address_reg;
        `OFS_CNT:      prdata_reg <= transfer_count_reg;
        `OFS_CTRL:     prdata_reg <= {21'h000000, channel_control_reg};
        `OFS_OPER:     prdata_reg <= {29'h00000000, dma_operation_reg};
        `OFS_IRQ_STAT: prdata_reg <= {29'h00000000, irq_stat_reg};
        `OFS_IRQ_EN:   prdata_reg <= {29'h00000000, irq_en_reg};
        `OFS_STATE:    prdata_reg <= {28'h0000000, state_reg, units_done};
        default:       prdata_reg <= `ZERO32;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Address and count registers
  // ----------------------------------------------------------------------
  // Unit completion outranks a software write in the same cycle
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      source_address_reg <= `ZERO32;
      source_shadow_reg  <= `ZERO32;
      dest_address_reg   <= `ZERO32;
      transfer_count_reg <= `ZERO32;
    end else if (unit_end) begin
      // restore start address at the reload point
      if (wrap && reload_on) begin
        source_address_reg <= source_shadow_reg;
      end else begin
        source_address_reg <= src_step;
      end
      dest_address_reg   <= dst_step;
      transfer_count_reg <= transfer_count_reg - `CNT_ONE;
    end else if (wr_en) begin
      // shadow copy taken at write time
      if (paddr_i == `OFS_SRC) begin
        source_address_reg <= pwdata_i;
        source_shadow_reg  <= pwdata_i;
      end
      if (paddr_i == `OFS_DST) begin
        dest_address_reg <= pwdata_i;
      end
      if (paddr_i == `OFS_CNT) begin
        transfer_count_reg <= pwdata_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control and operation registers
  // ----------------------------------------------------------------------
  // Flags: software may only clear, hardware set wins over clear
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      channel_control_reg <= `CTRL_RST;
      dma_operation_reg   <= {`OPER_W{1'b0}};
    end else begin
      if (wr_en && (paddr_i == `OFS_CTRL)) begin
        channel_control_reg <= pwdata_i[`CTRL_W-1:0] &
                               ~(11'h001 << `CTRL_TE) |
                               (channel_control_reg &
                                pwdata_i[`CTRL_W-1:0] &
                                (11'h001 << `CTRL_TE));
      end
      if (unit_end && last_unit) begin
        channel_control_reg[`CTRL_TE] <= 1'b1;
      end
      if (wr_en && (paddr_i == `OFS_OPER)) begin
        dma_operation_reg[`OPER_DME]  <= pwdata_i[`OPER_DME];
        dma_operation_reg[`OPER_NMIF] <= nmi_flag &
                                         pwdata_i[`OPER_NMIF];
        dma_operation_reg[`OPER_AE]   <= address_error_flag &
                                         pwdata_i[`OPER_AE];
      end
      if (nmi_i) begin
        dma_operation_reg[`OPER_NMIF] <= 1'b1;
      end
      if (addr_error_i) begin
        dma_operation_reg[`OPER_AE] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign ev_set = {addr_error_i, unit_end && reload_halt,
                   unit_end && last_unit};

  // Sticky status; set wins over a write-one clear
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= {`EV_W{1'b0}};
      irq_en_reg   <= {`EV_W{1'b0}};
    end else begin
      if (wr_en && (paddr_i == `OFS_IRQ_EN)) begin
        irq_en_reg <= pwdata_i[`EV_W-1:0];
      end
      if (wr_en && (paddr_i == `OFS_IRQ_CLR)) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata_i[`EV_W-1:0]) | ev_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_set;
      end
    end
  end

  // end interrupt only from the end flag, never the reload point
  assign transfer_end_interrupt_o = transfer_end_flag &&
                                    end_interrupt_enable;
  assign irq_o = |(irq_stat_reg & irq_en_reg);

endmodule // dma_reload_channel

// ==== dma_reload_sva.sv ====
// Checker on the reload channel ports, bound to the channel
`timescale 1ns/1ps
module dma_reload_sva (
  input wire        clk_i,
  input wire        reset_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire        periph_req_i,
  input wire        periph_flag_clr_o,
  input wire        bus_req_o,
  input wire        bus_grant_i,
  input wire        unit_valid_o,
  input wire        unit_done_i,
  input wire [31:0] src_addr_o,
  input wire        transfer_end_interrupt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ------------------------------------------------------------
  // Bus ownership
  // ------------------------------------------------------------
  a_unit_needs_bus: assert property (
    unit_valid_o |-> bus_req_o) else $error("unit without bus request");
  a_unit_after_grant: assert property (
    $rose(unit_valid_o) |-> $past(bus_grant_i))
    else $error("unit started without grant");
  a_unit_holds: assert property (
    unit_valid_o && !unit_done_i |=> unit_valid_o)
    else $error("unit dropped before done");
  a_req_on_periph: assert property (
    $rose(bus_req_o) |-> $past(periph_req_i))
    else $error("bus request without peripheral request");

  // ------------------------------------------------------------
  // Reload point and end
  // ------------------------------------------------------------
  a_clr_after_unit: assert property (
    periph_flag_clr_o |-> $past(unit_valid_o && unit_done_i))
    else $error("flag clear not after a unit");
  a_clr_releases: assert property (
    periph_flag_clr_o |-> !bus_req_o ##1 !periph_flag_clr_o)
    else $error("bus kept or clear pulse too long");
  a_src_moves: assert property (
    !$stable(src_addr_o) |-> $past(unit_valid_o && unit_done_i ||
      psel_i && penable_i && pwrite_i && paddr_i == 8'h00))
    else $error("source address changed without cause");
  a_end_no_unit: assert property (
    transfer_end_interrupt_o |-> !unit_valid_o)
    else $error("end interrupt while transferring");
  a_end_cause: assert property (
    $rose(transfer_end_interrupt_o) |->
      $past(unit_valid_o && unit_done_i || psel_i && pwrite_i))
    else $error("end interrupt without cause");

  // Main scenarios reached
  c_reload: cover property (periph_flag_clr_o);
  c_end: cover property ($rose(transfer_end_interrupt_o));
  c_burst: cover property (unit_valid_o && unit_done_i ##1 unit_valid_o);
endmodule // dma_reload_sva

bind dma_reload_channel dma_reload_sva i_sva (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .periph_req_i(periph_req_i), .periph_flag_clr_o(periph_flag_clr_o),
  .bus_req_o(bus_req_o), .bus_grant_i(bus_grant_i),
  .unit_valid_o(unit_valid_o), .unit_done_i(unit_done_i),
  .src_addr_o(src_addr_o),
  .transfer_end_interrupt_o(transfer_end_interrupt_o));

// ==== far_side_model.sv ====
// Far side: CPU bus arbiter and requesting converter
`timescale 1ns/1ps
module far_side_model (
  input  wire clk_i,
  input  wire reset_n_i,
  input  wire kick_i,
  input  wire slow_i,
  input  wire periph_flag_clr_i,
  input  wire bus_req_i,
  input  wire unit_valid_i,
  output reg  periph_req_o,
  output wire bus_grant_o,
  output reg  unit_done_o
);
  reg       grant_q;
  reg [1:0] wait_q;

  // flag held until the channel clears it
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_req_o <= 1'b0;
      grant_q      <= 1'b0;
    end else begin
      grant_q <= bus_req_i;
      if (kick_i)
        periph_req_o <= 1'b1;
      else if (periph_flag_clr_i)
        periph_req_o <= 1'b0;
    end
  end

  // Grant a cycle late, withdrawn with the request, never stale
  assign bus_grant_o = bus_req_i & grant_q;

  // Unit done after 0 or 3 waits; slow mode stalls the bus side
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q      <= 2'h0;
      unit_done_o <= 1'b0;
    end else if (!unit_valid_i || unit_done_o) begin
      wait_q      <= 2'h0;
      unit_done_o <= 1'b0;
    end else if (wait_q >= (slow_i ? 2'h3 : 2'h0)) begin
      unit_done_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule // far_side_model

// ==== tb_top.sv ====
// Testbench: reload channel scenarios over APB
`timescale 1ns/1ps
`include "dma_reload_defines.vh"
module tb_top;
  reg         clk_i, reset_n_i, psel, penable, pwrite, kick, slow, breq_q;
  reg         nmi, aerr, stby, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata, src, dst;
  wire        pready, pslverr, preq, fclr, breq, grant;
  wire        uvalid, udone, tend, irq;
  wire [1:0]  usize;
  integer     failures, tests_run, cyc, falls, clrs;

  dma_reload_channel i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .periph_req_i(preq), .periph_flag_clr_o(fclr),
    .bus_req_o(breq), .bus_grant_i(grant), .unit_valid_o(uvalid),
    .unit_done_i(udone), .src_addr_o(src), .dst_addr_o(dst),
    .unit_size_o(usize), .nmi_i(nmi), .addr_error_i(aerr),
    .standby_i(stby), .transfer_end_interrupt_o(tend), .irq_o(irq));

  far_side_model i_far (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .kick_i(kick), .slow_i(slow),
    .periph_flag_clr_i(fclr), .bus_req_i(breq), .unit_valid_i(uvalid),
    .periph_req_o(preq), .bus_grant_o(grant), .unit_done_o(udone));

  always #5 clk_i = ~clk_i;

  // Count bus releases, flag clears and the hang limit
  always @(posedge clk_i) begin
    breq_q <= breq;
    if (breq_q && !breq) falls = falls + 1;
    if (fclr) clrs = clrs + 1;
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      end_sim;
    end
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One APB transfer; read data taken at the ready edge
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (!pready) @(posedge clk_i);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Converter raises its flag; wait for the bus to be handed back
  task run_burst;
    begin
      kick <= 1'b1;
      @(posedge clk_i);
      kick <= 1'b0;
      wait (breq);
      wait (!breq);
      repeat (2) @(negedge clk_i);
    end
  endtask

  task end_sim;
    begin
      $display("Comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    clk_i = 0; reset_n_i = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; kick = 0; slow = 0; breq_q = 0;
    failures = 0; tests_run = 0; cyc = 0; falls = 0; clrs = 0;
    nmi = 0; aerr = 0; stby = 0; err = 0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset control value, unmapped word reads zero
    apb(0, `OFS_CTRL, 0); chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(0, 8'h40, 0); chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    // ----------------------------------------------------------
    // Reload on: byte units, both incrementing, count of eight
    // ----------------------------------------------------------
    apb(1, `OFS_SRC, 32'hffff83f0);
    apb(1, `OFS_DST, 32'hfffff000);
    apb(1, `OFS_CNT, 32'h8);
    apb(1, `OFS_IRQ_EN, 32'h7);
    apb(1, `OFS_OPER, 32'h1);
    // burst with reload, end interrupt enabled
    apb(1, `OFS_CTRL, 32'hbd);
    run_burst;
    chk(src, 32'hffff83f0);
    chk(dst, 32'hfffff004);
    chk({30'h0, usize}, 32'h0);
    chk(falls, 1);
    chk(clrs, 1);
    chk({31'h0, preq}, 32'h0);
    chk({31'h0, tend}, 32'h0);
    apb(0, `OFS_CNT, 0); chk(rd, 32'h4);
    apb(0, `OFS_IRQ_STAT, 0); chk(rd, 32'h2);
    apb(0, `OFS_STATE, 0); chk({30'h0, rd[1:0]}, 32'h0);
    apb(1, `OFS_IRQ_CLR, 32'h2);
    @(negedge clk_i); chk({31'h0, irq}, 32'h0);
    // Idle until the converter asks again
    repeat (4) @(negedge clk_i); chk({31'h0, breq}, 32'h0);
    run_burst;
    chk(dst, 32'hfffff008);
    chk({31'h0, tend}, 32'h1);
    chk(clrs, 1);
    apb(0, `OFS_CNT, 0); chk(rd, 32'h0);
    apb(0, `OFS_CTRL, 0); chk(rd, 32'hbf);
    // Mask, unmask and clear the end event
    apb(1, `OFS_IRQ_EN, 32'h0);
    @(negedge clk_i); chk({31'h0, irq}, 32'h0);
    apb(1, `OFS_IRQ_EN, 32'h7);
    @(negedge clk_i); chk({31'h0, irq}, 32'h1);
    apb(1, `OFS_IRQ_CLR, 32'h7);
    @(negedge clk_i); chk({31'h0, irq}, 32'h0);
    // ----------------------------------------------------------
    // Reload off, decrementing destination, slow bus side
    // ----------------------------------------------------------
    apb(1, `OFS_CTRL, 32'h0);
    slow <= 1'b1;
    apb(1, `OFS_SRC, 32'h100);
    apb(1, `OFS_DST, 32'h200);
    apb(1, `OFS_CNT, 32'h8);
    apb(1, `OFS_CTRL, 32'h135);
    run_burst;
    chk(src, 32'h108);
    chk(dst, 32'h1f8);
    chk(falls, 3);
    chk(clrs, 1);
    chk({31'h0, tend}, 32'h1);
    // ----------------------------------------------------------
    // Standby after the first unit restarts the four-unit count
    // ----------------------------------------------------------
    apb(1, `OFS_SRC, 32'h300);
    apb(1, `OFS_DST, 32'h400);
    apb(1, `OFS_CNT, 32'h8);
    apb(1, `OFS_CTRL, 32'hbd);
    wait (udone);
    wait (!udone);
    stby <= 1'b1;
    @(posedge clk_i);
    stby <= 1'b0;
    wait (!breq);
    repeat (2) @(negedge clk_i);
    chk(src, 32'h300);
    chk(dst, 32'h405);
    chk(clrs, 2);
    apb(0, `OFS_CNT, 0); chk(rd, 32'h3);
    // NMI sets its flag; address error sets its flag and the error event
    nmi <= 1'b1;
    @(posedge clk_i);
    nmi <= 1'b0;
    apb(0, `OFS_OPER, 0); chk(rd, 32'h3);
    aerr <= 1'b1;
    @(posedge clk_i);
    aerr <= 1'b0;
    apb(0, `OFS_IRQ_STAT, 0); chk(rd, 32'h7);
    apb(1, `OFS_OPER, 32'h1);
    apb(0, `OFS_OPER, 0); chk(rd, 32'h1);
    end_sim;
  end
endmodule // tb_top
